/* File: hdl/pfsb_pkg.sv */
/*
 * Shared constants and types of the fault-status byte block: command codes, bit
 * positions, supported-bit masks, reset values and the link state machine states.
 * Assumes nothing of its surroundings; imported whole by every design module.
 */
package pfsb_pkg;

   // ************************************************************
   // Command codes of the three status bytes and of the clear
   // ************************************************************
   localparam logic [7:0] OFS_VOUT_STATUS  = 8'h7a;
   localparam logic [7:0] OFS_IOUT_STATUS  = 8'h7b;
   localparam logic [7:0] OFS_INPUT_STATUS = 8'h7c;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;  // Send-byte clear of every latched flag
   localparam logic [6:0] DEV_ADDR         = 7'h24;  // Arbitrary value, set per board

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int OV_FAULT_BIT = 7;
   localparam int LOW_IN_BIT   = 3;
   localparam int NUM_PHASES   = 2;
   localparam int NUM_OVP_SRC  = 3;  // Fixed, tracking, prebiased

   // ************************************************************
   // Supported latched bits; all others read as zero except live input bit 3
   // ************************************************************
   localparam logic [7:0] SUPP_VOUT   = 8'hfc;
   localparam logic [7:0] SUPP_IOUT   = 8'hb0;
   localparam logic [7:0] SUPP_INPUT  = 8'ha0;
   localparam logic [7:0] ALERT_VOUT  = 8'h7c;  // Output bits besides the overvoltage fault
   localparam logic [2:0] SUPP_OVPSRC = 3'h7;

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [7:0] RST_FLAGS   = 8'h00;
   localparam logic       RST_LOW_IN  = 1'b1;   // Input reads low until the first sample
   localparam logic [2:0] BIT_LAST    = 3'h7;   // Index of the eighth bit of a byte
   localparam logic [1:0] RST_SYNC    = 2'h0;

   typedef enum logic [2:0] {
      PFSB_IDLE, PFSB_ADDR, PFSB_CMD, PFSB_WDATA, PFSB_ACK, PFSB_RDATA, PFSB_RREL
   } pfsb_state_t;

endpackage

/* File: hdl/pfsb_flags.sv */
/*
 * One byte (or narrower) of latched write-one-to-clear flags.
 * Assumes set and clear come from logic on the same clock; unsupported bits are
 * held at zero by the SUPP parameter.
 */
`timescale 1ns/100ps

module pfsb_flags
   import pfsb_pkg::*;
#(
   parameter int           W    = 8,
   parameter logic [W-1:0] SUPP = '1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);

   logic [W-1:0] q_d;

   // Set beats clear in the same cycle so no event is lost; zero bits of clr hold
   always_comb begin
      q_d = ((q & ~clr) | set) & SUPP;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= q_d;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      (set != '0) |=> ((q & $past(set) & SUPP) == ($past(set) & SUPP));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag set lost");

   property p_clr_one;
      @(posedge clk) disable iff (!rst_n)
      ((clr & ~set) != '0) |=> ((q & $past(clr) & ~$past(set)) == '0);
   endproperty
   a_clr_one: assert property (p_clr_one) else $error("flag not cleared");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      (set == '0 && clr == '0) |=> (q == $past(q));
   endproperty
   a_hold: assert property (p_hold) else $error("flag changed without cause");

   property p_unsupp;
      @(posedge clk) disable iff (!rst_n)
      (q & ~SUPP) == '0;
   endproperty
   a_unsupp: assert property (p_unsupp) else $error("unsupported bit set");

endmodule

/* File: hdl/pfsb_status.sv */
/*
 * Fault-status bytes for output voltage, output current and input, reached by
 * read-byte / write-byte / send-byte transactions on a two-wire management link.
 * Assumes fault detectors and mask sources run on clk; scl/sda are asynchronous
 * pins and are synchronised here. The bench resolves the open-drain sda wire.
 */
`timescale 1ns/100ps

// Contract
// - Each status register is one byte, read and written by byte transactions.
// - Latched flags clear on written 1 or on the clear-faults command.
// - Output-voltage bit 7 latches output overvoltage fault; resets to 0.
// - Output-voltage bit 6 latches output overvoltage warning.
// - Output-voltage bit 5 latches output undervoltage warning.
// - Output-voltage bit 4 latches output undervoltage fault.
// - Output-voltage bit 3 latches setpoint outside min/max limits.
// - Output-voltage bit 2 latches turn-on timeout.
// - Output-voltage bits 1:0 are read-only zero.
// - Overvoltage fault mask covers three sources, each also separately maskable.
// - Every alerting status bit has its own mask bit; both phases share one mask bit per current or input bit.
// - Output-current bit 7 latches overcurrent fault.
// - Output-current bit 5 latches overcurrent warning.
// - Output-current bit 4 latches undercurrent fault, cleared by written 1.
// - Output-current bit 6 and bits 3:0 are read-only zero.
// - Input bit 7 latches input overvoltage fault.
// - Input bit 5 latches input undervoltage warning.
// - Input bit 3 is live: 1 while input is below its on level.
// - Input bits 6, 4 and 2:0 are read-only zero.
// - Summary bits 15:13 report any flag in the three bytes.
// - Live low-input bit never raises alert and is set after reset.
// - Input undervoltage warning masked until input first exceeds on level.
module pfsb_status
   import pfsb_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe,
   input  wire logic                  phase_sel,
   input  wire logic [NUM_OVP_SRC-1:0] ovp_src,
   input  wire logic                  out_overvolt_warn,
   input  wire logic                  out_undervolt_warn,
   input  wire logic                  out_undervolt_fault,
   input  wire logic                  out_setpoint_limit_violation,
   input  wire logic                  turn_on_timeout,
   input  wire logic [NUM_PHASES-1:0] out_overcurrent_fault,
   input  wire logic [NUM_PHASES-1:0] out_overcurrent_warn,
   input  wire logic [NUM_PHASES-1:0] out_undercurrent_fault,
   input  wire logic [NUM_PHASES-1:0] in_overvolt_fault,
   input  wire logic [NUM_PHASES-1:0] in_undervolt_warn,
   input  wire logic                  input_below_on_level,
   input  wire logic [7:0]            alert_suppress_vout,
   input  wire logic [7:0]            alert_suppress_iout,
   input  wire logic [7:0]            alert_suppress_input,
   input  wire logic [NUM_OVP_SRC-1:0] alert_suppress_ext_cmd,
   output logic                       alert_req,
   output logic [2:0]                 status_summary
);

   // ************************************************************
   // Reset release and pin synchronisers
   // ************************************************************
   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       scl_p_q;
   logic       sda_p_q;

   // Reset enters asynchronously but is released on a clock edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= RST_SYNC;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Two stages on each pin; the third copy is only for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_p_q    <= scl_sync_q[1];
         sda_p_q    <= sda_sync_q[1];
      end
   end

   logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_s    = scl_sync_q[1];
   assign sda_s    = sda_sync_q[1];
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ************************************************************
   // Link state machine: address, command, data and acknowledge
   // ************************************************************
   pfsb_state_t st_q, st_d, nxt_q, nxt_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d, cmd_q, cmd_d, byte_in, rd_byte;
   logic        oe_q, oe_d, ack_q, ack_d, wstb_q, wstb_d, cf_q, cf_d, cfp_q, cfp_d;

   assign byte_in = {sh_q[6:0], sda_s};

   // Only one byte per transaction is supported; further bytes are not acknowledged
   always_comb begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      cmd_d = cmd_q;
      oe_d = oe_q;
      ack_d = ack_q;
      wstb_d = 1'b0;
      cf_d = 1'b0;
      cfp_d = cfp_q;
      if (stop_ev) begin
         st_d  = PFSB_IDLE;
         oe_d  = 1'b0;
         ack_d = 1'b0;
         cf_d  = cfp_q;
         cfp_d = 1'b0;
      end else if (start_ev) begin
         st_d  = PFSB_ADDR;
         cnt_d = '0;
         oe_d  = 1'b0;
         ack_d = 1'b0;
      end else begin
         case (st_q)
            PFSB_ADDR, PFSB_CMD, PFSB_WDATA: begin
               if (scl_rise) begin
                  sh_d  = byte_in;
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == BIT_LAST) begin
                     st_d = PFSB_IDLE;
                     if (st_q == PFSB_ADDR && byte_in[7:1] == DEV_ADDR) begin
                        st_d  = PFSB_ACK;
                        nxt_d = byte_in[0] ? PFSB_RDATA : PFSB_CMD;
                     end else if (st_q == PFSB_CMD) begin
                        cmd_d = byte_in;
                        if (byte_in == CMD_CLEAR_FAULTS ||
                            (byte_in >= OFS_VOUT_STATUS && byte_in <= OFS_INPUT_STATUS)) begin
                           st_d  = PFSB_ACK;
                           nxt_d = PFSB_WDATA;
                           cfp_d = (byte_in == CMD_CLEAR_FAULTS);
                        end
                     end else if (st_q == PFSB_WDATA) begin
                        st_d   = PFSB_ACK;
                        nxt_d  = PFSB_IDLE;
                        wstb_d = 1'b1;
                        cfp_d  = 1'b0;
                     end
                  end
               end
            end
            PFSB_ACK: begin
               if (scl_fall) begin
                  if (!ack_q) begin
                     oe_d  = 1'b1;
                     ack_d = 1'b1;
                  end else begin
                     ack_d = 1'b0;
                     cnt_d = '0;
                     st_d  = nxt_q;
                     oe_d  = 1'b0;
                     if (nxt_q == PFSB_RDATA) begin
                        oe_d = ~rd_byte[7];
                        sh_d = {rd_byte[6:0], 1'b0};
                     end
                  end
               end
            end
            PFSB_RDATA: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == BIT_LAST) begin
                     st_d = PFSB_RREL;
                  end
               end else if (scl_fall) begin
                  oe_d = ~sh_q[7];
                  sh_d = {sh_q[6:0], 1'b0};
               end
            end
            PFSB_RREL: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  st_d = PFSB_IDLE;
               end
            end
            default: begin
               st_d = PFSB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= PFSB_IDLE;
         nxt_q  <= PFSB_IDLE;
         cnt_q  <= '0;
         sh_q   <= RST_FLAGS;
         cmd_q  <= RST_FLAGS;
         oe_q   <= 1'b0;
         ack_q  <= 1'b0;
         wstb_q <= 1'b0;
         cf_q   <= 1'b0;
         cfp_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         nxt_q  <= nxt_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         cmd_q  <= cmd_d;
         oe_q   <= oe_d;
         ack_q  <= ack_d;
         wstb_q <= wstb_d;
         cf_q   <= cf_d;
         cfp_q  <= cfp_d;
      end
   end

   assign sda_oe = oe_q;
   assign sda_o  = 1'b0;  // Open drain: only ever pulls low

   // ************************************************************
   // Latched flag bytes
   // ************************************************************
   logic [7:0]             vout_q, clr_v, clr_i, clr_in;
   logic [NUM_OVP_SRC-1:0] ovps_q;
   logic [7:0]             iout_q [NUM_PHASES];
   logic [7:0]             inp_q  [NUM_PHASES];
   logic                   low_in_q, armed_q;

   // Written ones clear only the addressed byte of the selected phase
   always_comb begin
      clr_v  = {8{cf_q}} | ((wstb_q && cmd_q == OFS_VOUT_STATUS) ? sh_q : 8'h00);
      clr_i  = (wstb_q && cmd_q == OFS_IOUT_STATUS) ? sh_q : 8'h00;
      clr_in = (wstb_q && cmd_q == OFS_INPUT_STATUS) ? sh_q : 8'h00;
   end

   pfsb_flags #(.W(8), .SUPP(SUPP_VOUT)) u_vout (
      .clk   (clk),
      .rst_n (rst_n),
      .set   ({|ovp_src,
               out_overvolt_warn,
               out_undervolt_warn,
               out_undervolt_fault,
               out_setpoint_limit_violation,
               turn_on_timeout,
               2'h0}),
      .clr   (clr_v),
      .q     (vout_q)
   );

   // Source record behind the overvoltage fault, cleared with that bit
   pfsb_flags #(.W(NUM_OVP_SRC), .SUPP(SUPP_OVPSRC)) u_ovps (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (ovp_src),
      .clr   ({NUM_OVP_SRC{clr_v[OV_FAULT_BIT]}}),
      .q     (ovps_q)
   );

   // One current byte and one input byte per phase
   for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
      logic sel;
      assign sel = (phase_sel == 1'(p));
      pfsb_flags #(.W(8), .SUPP(SUPP_IOUT)) u_iout (
         .clk   (clk),
         .rst_n (rst_n),
         .set   ({out_overcurrent_fault[p],
                  1'b0,
                  out_overcurrent_warn[p],
                  out_undercurrent_fault[p],
                  4'h0}),
         .clr   ({8{cf_q}} | (sel ? clr_i : 8'h00)),
         .q     (iout_q[p])
      );
      pfsb_flags #(.W(8), .SUPP(SUPP_INPUT)) u_inp (
         .clk   (clk),
         .rst_n (rst_n),
         .set   ({in_overvolt_fault[p],
                  1'b0,
                  in_undervolt_warn[p] & armed_q,
                  5'h00}),
         .clr   ({8{cf_q}} | (sel ? clr_in : 8'h00)),
         .q     (inp_q[p])
      );
   end

   // ************************************************************
   // Live input level, read mux, summary and alert
   // ************************************************************
   logic       low_in_d, armed_d, alert_d;
   logic [2:0] sum_d;

   // Alert ORs every phase; the live bit is deliberately left out of it
   always_comb begin
      low_in_d = input_below_on_level;
      armed_d  = armed_q | ~input_below_on_level;
      case (cmd_q)
         OFS_VOUT_STATUS:  rd_byte = vout_q;
         OFS_IOUT_STATUS:  rd_byte = iout_q[phase_sel];
         OFS_INPUT_STATUS: rd_byte = inp_q[phase_sel] | ({7'h00, low_in_q} << LOW_IN_BIT);
         default:          rd_byte = 8'h00;
      endcase
      sum_d = {|vout_q, |iout_q[phase_sel], |inp_q[phase_sel]};
      alert_d = (|(vout_q & ~alert_suppress_vout & ALERT_VOUT)) |
                (vout_q[OV_FAULT_BIT] & ~alert_suppress_vout[OV_FAULT_BIT] &
                 (|(ovps_q & ~alert_suppress_ext_cmd)));
      for (int p = 0; p < NUM_PHASES; p++) begin
         alert_d = alert_d | (|(iout_q[p] & ~alert_suppress_iout)) |
                   (|(inp_q[p] & ~alert_suppress_input));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_in_q       <= RST_LOW_IN;
         armed_q        <= 1'b0;
         status_summary <= 3'h0;
         alert_req      <= 1'b0;
      end else begin
         low_in_q       <= low_in_d;
         armed_q        <= armed_d;
         status_summary <= sum_d;
         alert_req      <= alert_d;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_ovf_latch;
      @(posedge clk) disable iff (!rst_n)
      (|ovp_src) |=> vout_q[7] ##1 (vout_q[7] || $past(clr_v[7]));
   endproperty
   a_ovf_latch: assert property (p_ovf_latch) else $error("overvoltage not latched");

   property p_ton_latch;
      @(posedge clk) disable iff (!rst_n)
      turn_on_timeout |=> vout_q[2];
   endproperty
   a_ton_latch: assert property (p_ton_latch) else $error("timeout not latched");

   property p_oc_latch;
      @(posedge clk) disable iff (!rst_n)
      out_overcurrent_fault[1] |=> iout_q[1][7];
   endproperty
   a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");

   property p_live;
      @(posedge clk) disable iff (!rst_n)
      ##1 (low_in_q == $past(input_below_on_level));
   endproperty
   a_live: assert property (p_live) else $error("live input bit stale");

   property p_live_quiet;
      @(posedge clk) disable iff (!rst_n)
      (vout_q == 8'h00 && iout_q[0] == 8'h00 && iout_q[1] == 8'h00 &&
       inp_q[0] == 8'h00 && inp_q[1] == 8'h00) |=> !alert_req;
   endproperty
   a_live_quiet: assert property (p_live_quiet) else $error("alert without flag");

   property p_uvw_gate;
      @(posedge clk) disable iff (!rst_n)
      (!armed_q && !inp_q[0][5]) |=> !inp_q[0][5];
   endproperty
   a_uvw_gate: assert property (p_uvw_gate) else $error("warning before arming");

   property p_summary;
      @(posedge clk) disable iff (!rst_n)
      (vout_q != 8'h00) |=> status_summary[2];
   endproperty
   a_summary: assert property (p_summary) else $error("summary missed");

   property p_ext_mask;
      @(posedge clk) disable iff (!rst_n)
      (vout_q[7] && !alert_suppress_vout[7] && ovps_q[0] && !alert_suppress_ext_cmd[0])
      |=> alert_req;
   endproperty
   a_ext_mask: assert property (p_ext_mask) else $error("unmasked source no alert");

   property p_ack_drive;
      @(posedge clk) disable iff (!rst_n)
      (st_q == PFSB_ACK && scl_fall && !ack_q && !start_ev && !stop_ev) |=> sda_oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge");

   c_read:  cover property (@(posedge clk) disable iff (!rst_n) st_q == PFSB_RREL);
   c_clear: cover property (@(posedge clk) disable iff (!rst_n) cf_q);
   c_write: cover property (@(posedge clk) disable iff (!rst_n) wstb_q);
   c_alert: cover property (@(posedge clk) disable iff (!rst_n) $rose(alert_req));

endmodule

/* File: verification/pfsb_host_model.sv */
/*
 * Host side of the management link: start, byte, read and stop sequences.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/100ps

module pfsb_host_model
   import pfsb_pkg::*;
(
   output logic       scl,
   output logic       sda_pull,
   input  wire logic  sda,
   output logic [7:0] rd_data,
   output logic       rd_valid
);
   localparam time Q = 40ns;

   // ************************************************************
   // Bit level; clock stands high between frames
   // ************************************************************
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_data = 8'h00;
      rd_valid = 1'b0;
   end

   task automatic bit_io(input logic b, output logic s);
      sda_pull = ~b;  // Releasing lets the pull-up or the device decide
      #Q;
      scl = 1'b1;
      #Q;
      s = sda;  // Sampled mid-high, well after the device's output settles
      #Q;
      scl = 1'b0;
      #Q;
   endtask

   task automatic start();
      sda_pull = 1'b0;
      #Q;
      scl = 1'b1;
      #Q;
      sda_pull = 1'b1;
      #Q;
      scl = 1'b0;
      #Q;
   endtask

   task automatic stop();
      sda_pull = 1'b1;
      #Q;
      scl = 1'b1;
      #Q;
      sda_pull = 1'b0;
      #(4*Q);
   endtask

   // One whole byte, MSB first, then the acknowledge slot
   task automatic byte_out(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
   endtask

   // ************************************************************
   // Transactions
   // ************************************************************
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      start();
      byte_out({DEV_ADDR, 1'b0});
      byte_out(cmd);
      byte_out(d);
      stop();
   endtask

   task automatic clr();
      start();
      byte_out({DEV_ADDR, 1'b0});
      byte_out(CMD_CLEAR_FAULTS);
      stop();
   endtask

   task automatic rd(input logic [7:0] cmd);
      logic [7:0] d;
      logic       s;
      start();
      byte_out({DEV_ADDR, 1'b0});
      byte_out(cmd);
      start();
      byte_out({DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      rd_data = d;  // Settles long before the valid strobe, so the bench never races it
      bit_io(1'b1, s);  // Not-acknowledge ends the read
      stop();
      rd_valid = 1'b1;
      #Q;
      rd_valid = 1'b0;
   endtask
endmodule

/* File: verification/testbench.sv */
/*
 * Self-checking bench of the fault-status bytes: pulses fault events, reads,
 * write-clears and clear-faults through the host model.
 * Assumes the host model above; the data wire has a pull-up.
 */
`timescale 1ns/100ps

module testbench;
   import pfsb_pkg::*;
   logic       clk = 1'b0, rstn = 1'b0, ps = 1'b0, lin = 1'b1;
   logic [2:0] ovp, sx = 3'h0;
   logic       ovw, uvw, uvf, slv, ton;
   logic [1:0] ocf, ocw, ucf, iovf, iuvw;
   logic [7:0] sv = 8'h00, si = 8'h00, sn = 8'h00, q[$], v;
   logic [31:0] r = 32'ha886f8ee;
   logic       sda_o, sda_oe, pull, scl, alert, rv;
   logic [2:0] summ;
   logic [7:0] rdat;
   int         errors = 0, checks_done = 0;
   wire        sda = (sda_oe ? sda_o : 1'b1) & ~pull;

   pfsb_host_model pfsb_host_model_i (.scl(scl), .sda_pull(pull), .sda(sda), .rd_data(rdat),
      .rd_valid(rv));
   pfsb_status pfsb_status_i (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .phase_sel(ps), .ovp_src(ovp), .out_overvolt_warn(ovw),
      .out_undervolt_warn(uvw), .out_undervolt_fault(uvf), .out_setpoint_limit_violation(slv),
      .turn_on_timeout(ton), .out_overcurrent_fault(ocf), .out_overcurrent_warn(ocw),
      .out_undercurrent_fault(ucf), .in_overvolt_fault(iovf), .in_undervolt_warn(iuvw),
      .input_below_on_level(lin), .alert_suppress_vout(sv), .alert_suppress_iout(si),
      .alert_suppress_input(sn), .alert_suppress_ext_cmd(sx), .alert_req(alert),
      .status_summary(summ));

   // ************************************************************
   // Clock, helpers and checking
   // ************************************************************
   always #2 clk = ~clk;

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Next value of the stimulus register
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // One-cycle event pulse; the phase index picks the per-phase lines
   task automatic pulse(input logic [7:0] vo, input logic [7:0] io, input logic [7:0] in, int p);
      {ovp, ovw, uvw, uvf, slv, ton} = {2'b00, vo[7:2]};
      {ocf[p], ocw[p], ucf[p], iovf[p], iuvw[p]} = {io[7], io[5], io[4], in[7], in[5]};
      tick(1);
      {ovp, ovw, uvw, uvf, slv, ton, ocf, ocw, ucf, iovf, iuvw} = '0;
      tick(3);
   endtask

   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      q.push_back(exp);
      pfsb_host_model_i.rd(cmd);
   endtask

   // Each finished read is compared against the oldest note
   always @(posedge rv) chk(rdat, q.pop_front());

   // Watchdog: roughly twice the length of the main sequence
   initial begin
      #200us;
      errors++;
      end_of_test();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {ovp, ovw, uvw, uvf, slv, ton, ocf, ocw, ucf, iovf, iuvw} = '0;
      tick(5);
      rstn = 1'b1;
      tick(6);
      chk(alert, 8'h00);
      pulse(8'h00, 8'h00, 8'h20, 0);
      rd(OFS_INPUT_STATUS, 8'h08);
      rd(OFS_VOUT_STATUS, 8'h00);
      lin = 1'b0;
      tick(3);
      r = lfsr(r);
      v = (r[7:0] | 8'hc0) & SUPP_VOUT;
      pulse(r[7:0] | 8'hc0, 8'h00, 8'h00, 0);
      rd(OFS_VOUT_STATUS, v);
      chk(summ, 8'h04);
      chk(alert, 8'h01);
      sv = 8'h7f;
      tick(3);
      chk(alert, 8'h01);
      sx = 3'h1;
      tick(3);
      chk(alert, 8'h00);
      sv = 8'hff;
      sx = 3'h0;
      tick(3);
      chk(alert, 8'h00);
      {sv, sx} = '0;
      pfsb_host_model_i.wr(OFS_VOUT_STATUS, 8'h87);
      rd(OFS_VOUT_STATUS, v & 8'h78);
      pulse(8'h00, 8'hb0, 8'ha0, 1);
      ps = 1'b1;
      rd(OFS_IOUT_STATUS, 8'hb0);
      rd(OFS_INPUT_STATUS, 8'ha0);
      chk(summ, 8'h07);
      pfsb_host_model_i.wr(OFS_INPUT_STATUS, 8'h28);
      rd(OFS_INPUT_STATUS, 8'h80);
      pfsb_host_model_i.wr(OFS_IOUT_STATUS, 8'h10);
      rd(OFS_IOUT_STATUS, 8'ha0);
      ps = 1'b0;
      rd(OFS_IOUT_STATUS, 8'h00);
      pfsb_host_model_i.clr();
      ps = 1'b1;
      rd(OFS_IOUT_STATUS, 8'h00);
      rd(OFS_INPUT_STATUS, 8'h00);
      rd(OFS_VOUT_STATUS, 8'h00);
      chk(alert, 8'h00);
      end_of_test();
   end
endmodule
